// file: verification/rpsm_drive_model.sv
// Far-side model: step table answering step_sel and a pulse engine.
// Assumes the engine loads on step_load and emits one pulse a cycle while busy until its count reaches the preset.
`timescale 1ns/10ps
module rpsm_drive_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Block side
	input wire logic [4:0] step_sel,
	input wire logic step_load,
	input wire logic busy,
	input wire logic extra,
	// Table answer and engine feedback
	output logic [15:0] tbl_freq,
	output logic [15:0] tbl_time,
	output logic [31:0] tbl_preset,
	output logic [15:0] tbl_option,
	output logic [15:0] tbl_next,
	output logic pulse_tick,
	output logic ramping
);
	logic [31:0] n_r;
	logic [31:0] p_r;
	always_comb begin
		tbl_freq = 16'h0064;
		tbl_time = 16'h000A;
		tbl_preset = 32'h0000_0002;
		tbl_option = 16'h0000;
		tbl_next = 16'h0000;
		case (step_sel)
			5'h01: begin
				tbl_time = 16'h0069;
				tbl_preset = 32'h0000_0028;
				tbl_next = 16'h0002;
			end
			5'h03: tbl_preset = 32'h0000_0028;
			5'h05: tbl_preset = 32'h0000_0000;
			5'h06: tbl_freq = 16'h0000;
			5'h07: tbl_time = 16'h0009;
			5'h08: tbl_option = 16'h0004;
			5'h09: tbl_next = 16'h0013;
			5'h0a: tbl_freq = 16'h000F;
			default: ;
		endcase
	end
	// One extra pulse past the preset only when the bench asks for it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			n_r <= 32'h0000_0000;
			p_r <= 32'h0000_0000;
		end else if (step_load) begin
			n_r <= 32'h0000_0000;
			p_r <= tbl_preset;
		end else if (pulse_tick) begin
			n_r <= n_r + 32'h0000_0001;
		end
	end
	assign pulse_tick = busy && !step_load && (n_r < p_r || (extra && n_r == p_r));
	assign ramping = busy && n_r < 32'h0000_0002;
endmodule

// file: verification/rpsm_top_bench.sv
// Self-checking bench: reads monitor words and flags while the drive model runs steps.
// Assumes rpsm_top and rpsm_drive_model are compiled before it.
`timescale 1ns/10ps
module rpsm_top_bench;
	logic mclk, rst_n, reg_wr, reg_rd, op_mode, word_order, exec_in, int_in, dir_in, scan_exec, extra;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, int_step, tbl_freq, tbl_time, tbl_option, tbl_next;
	logic [1:0] rev_mode;
	logic [4:0] start_step, step_sel;
	logic [31:0] tbl_preset;
	logic step_load, pulse_tick, ramping, flag_busy, flag_done, flag_ramp, flag_ovf, flag_dir;
	logic program_error_flag, blk_out;
	int err_total = 0;
	int n_checks = 0;
	logic [4:0] es [8] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h01, 5'h0a, 5'h0a};
	logic [15:0] ec [8] = '{16'h0003, 16'h0004, 16'h0005, 16'h0007, 16'h0008, 16'h0009, 16'h0004, 16'h0000};
	rpsm_top u_rpsm_top (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_mode(op_mode), .rev_mode(rev_mode),
		.word_order(word_order), .start_step(start_step), .int_step(int_step), .step_sel(step_sel),
		.step_load(step_load), .tbl_freq(tbl_freq), .tbl_time(tbl_time), .tbl_preset(tbl_preset),
		.tbl_option(tbl_option), .tbl_next(tbl_next), .exec_in(exec_in), .int_in(int_in), .dir_in(dir_in),
		.scan_exec(scan_exec), .pulse_tick(pulse_tick), .ramping(ramping), .flag_busy(flag_busy),
		.flag_done(flag_done), .flag_ramp(flag_ramp), .flag_ovf(flag_ovf), .flag_dir(flag_dir),
		.program_error_flag(program_error_flag), .blk_out(blk_out));
	rpsm_drive_model u_rpsm_drive_model (.mclk(mclk), .rst_n(rst_n), .step_sel(step_sel),
		.step_load(step_load), .busy(flag_busy), .extra(extra), .tbl_freq(tbl_freq), .tbl_time(tbl_time),
		.tbl_preset(tbl_preset), .tbl_option(tbl_option), .tbl_next(tbl_next), .pulse_tick(pulse_tick),
		.ramping(ramping));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Read strobe for one cycle; data is looked at only in the following cycle
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Drops exec long enough to reach idle, then raises it to start a step
	task automatic go(input logic [4:0] s);
		@(posedge mclk);
		exec_in <= 1'b0;
		start_step <= s;
		cyc(2);
		exec_in <= 1'b1;
		cyc(3);
	endtask
	task automatic wait_done;
		int i;
		i = 0;
		while (flag_done !== 1'b1 && i < 500) begin
			@(posedge mclk);
			#1 i++;
		end
		if (i == 500) begin
			err_total++;
			$display("MISMATCH %0t no completion", $time);
			end_of_test;
		end
	endtask
	initial begin
		{rst_n, reg_wr, reg_rd, op_mode, word_order, exec_in, int_in, dir_in, extra} = 9'h000;
		{reg_addr, reg_wdata, rev_mode} = 22'h00_0000;
		start_step = 5'h01;
		int_step = 16'h0001;
		scan_exec = 1'b1;
		cyc(8);
		rst_n <= 1'b1;
		for (int a = 0; a < 10; a++) rd(4'(a), 16'h0000);
		@(posedge mclk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, 4'h8, 16'h00AA};
		@(posedge mclk);
		reg_wr <= 1'b0;
		rd(4'h8, 16'h0000);
		go(5'h01);
		cyc(1);
		#1 chk(16'({flag_ramp, flag_busy, flag_done}), 16'h0006);
		rd(4'h1, 16'h0001);
		rd(4'h0, 16'h0002);
		rd(4'h2, 16'h0064);
		rd(4'h3, 16'h0064);
		rd(4'h4, 16'h0000);
		rd(4'h5, 16'h0028);
		wait_done;
		cyc(1);
		#1 chk(16'({blk_out, flag_busy, flag_ramp}), 16'h0004);
		rd(4'h1, 16'h0002);
		rd(4'h7, 16'h0002);
		rd(4'h8, 16'h0000);
		chk(16'(program_error_flag), 16'h0000);
		word_order <= 1'b1;
		rd(4'h4, 16'h0002);
		word_order <= 1'b0;
		exec_in <= 1'b0;
		cyc(2);
		#1 chk(16'(blk_out), 16'h0000);
		for (int k = 0; k < 8; k++) begin
			int_step <= (k == 5) ? 16'h0014 : 16'h0001;
			op_mode <= (k == 6);
			go(es[k]);
			rd(4'h8, ec[k]);
		end
		chk(16'(program_error_flag), 16'h0001);
		{op_mode, int_step} <= {1'b0, 16'h0004};
		go(5'h03);
		cyc(2);
		int_in <= 1'b1;
		cyc(4);
		rd(4'h1, 16'h0004);
		rd(4'h5, 16'h0002);
		int_in <= 1'b0;
		extra <= 1'b1;
		go(5'h04);
		wait_done;
		chk(16'({flag_ovf, flag_busy}), 16'h0002);
		rd(4'h7, 16'h0002);
		scan_exec <= 1'b0;
		go(5'h03);
		rd(4'h7, 16'h0002);
		scan_exec <= 1'b1;
		wait_done;
		rd(4'h7, 16'h0028);
		{rev_mode, dir_in} <= 3'h3;
		cyc(3);
		#1 chk(16'(flag_dir), 16'h0001);
		rev_mode <= 2'h0;
		cyc(3);
		#1 chk(16'(flag_dir), 16'h0000);
		end_of_test;
	end
endmodule

// file: verilog/rpsm_defs.svh
// Offsets, field limits, error codes and reset values of the ramp step monitor.
// Included by the design only; holds definitions only.
`ifndef RPSM_DEFS_SVH
`define RPSM_DEFS_SVH

// Monitor word offsets (nine read-only words)
`define RPSM_MON_WORDS 4'h9
`define RPSM_OFF_NEXT 4'h0
`define RPSM_OFF_RUN 4'h1
`define RPSM_OFF_FREQ 4'h2
`define RPSM_OFF_TIME 4'h3
`define RPSM_OFF_PRESET_A 4'h4
`define RPSM_OFF_PRESET_B 4'h5
`define RPSM_OFF_COUNT_A 4'h6
`define RPSM_OFF_COUNT_B 4'h7
`define RPSM_OFF_ERR 4'h8

// Status flag positions within the five-flag group
`define RPSM_FLAG_BUSY 0
`define RPSM_FLAG_DONE 1
`define RPSM_FLAG_RAMP 2
`define RPSM_FLAG_OVF 3
`define RPSM_FLAG_DIR 4

// Value limits
`define RPSM_STEP_MAX 16'h0012
`define RPSM_FREQ_MIN0 16'h0001
`define RPSM_FREQ_MIN1 16'h0014
`define RPSM_FREQ_MAX 16'h2710
`define RPSM_TIME_MIN 16'h000A
`define RPSM_TIME_MAX 16'h2710
`define RPSM_TIME_UNIT 16'h000A
`define RPSM_PRESET_MIN 32'h0000_0001
`define RPSM_PRESET_MAX 32'h05F5_E100
`define RPSM_OPT_MAX 16'h0003

// Error codes
`define RPSM_ERR_NONE 16'h0000
`define RPSM_ERR_PRESET 16'h0003
`define RPSM_ERR_FREQ 16'h0004
`define RPSM_ERR_TIME 16'h0005
`define RPSM_ERR_OPT 16'h0007
`define RPSM_ERR_NEXT 16'h0008
`define RPSM_ERR_INT 16'h0009

// Reset values
`define RPSM_RST_WORD 16'h0000
`define RPSM_RST_COUNT 32'h0000_0000

`endif

// file: verilog/rpsm_pkg.sv
// Types of the ramp step monitor: sequencer states and the packed state record.
// Assumes rpsm_defs.svh is on the include path.
package rpsm_pkg;

	typedef enum logic [1:0] {
		RPSM_IDLE,
		RPSM_CHECK,
		RPSM_RUN
	} rpsm_state_t;

	typedef struct packed {
		rpsm_state_t state;
		logic exec_q;
		logic int_q;
		logic [4:0] step_sel;
		logic step_load;
		logic [15:0] next_w;
		logic [15:0] run_w;
		logic [15:0] freq_w;
		logic [15:0] time_w;
		logic [31:0] preset;
		logic [31:0] cnt;
		logic [31:0] cnt_mon;
		logic [15:0] err;
		logic prog_err;
		logic busy;
		logic done;
		logic ramp;
		logic ovf;
		logic dir;
		logic out;
		logic [15:0] rdata;
	} rpsm_regs_t;

endpackage

// file: verilog/rpsm_top.sv
// Ramp pulse step monitor: sequences table steps, checks each step at its start,
// keeps the nine monitor words and five status flags, and drives the block output.
// Assumes a table holding step settings answers step_sel in the same cycle, and a
// ramp engine that reports emitted pulses and ramping; all inputs synchronous to mclk.
//
// What this block does
// - Nine consecutive 16-bit monitor words per channel, placed at a user base.
// - Monitor words are read-only to the program; only the block updates them.
// - Word 0 holds next step, 0 to 18; zero stops after current step.
// - Word 1 holds the running step number, 1 to 18.
// - Word 2 holds steady frequency; 1..10000 mode 0, 20..10000 mode 1.
// - Word 3 holds change time, 10..10000 ms, last decimal digit dropped.
// - Words 4 and 5 hold the preset count; word order follows setting.
// - Words 6 and 7 hold emitted count, refreshed whenever the block executes.
// - Invalid step at start sets program error flag and error code word 8.
// - Code 0 when fine; code 3 when preset outside 1 to 100,000,000.
// - Code 4 when steady frequency outside its mode range.
// - Code 5 when change time outside 10 to 10,000.
// - Code 7 when step option is not a valid encoding.
// - Code 8 when next step is outside 0 to 18.
// - Code 9 when interrupt target step is outside 1 to 18.
// - Five consecutive status flags per channel at a base ending in zero.
// - Flag 0 high while pulses flow; low on stop or preset reached.
// - Flag 1 set on completion or step zero; clear while pulses flow.
// - Flag 2 is 0 at steady frequency, 1 while ramping.
// - Flag 3 set on pulses beyond preset; pulses continue, count freezes.
// - Flag 4 is 0 forward, 1 reverse; follows direction input when reversible.
// - Block output mirrors completion but is low while execution input is low.
// - Interrupt input rising edge aborts step and restarts at interrupt target step.
// - Execution input rising edge starts output at the start step.
// - Operation mode selects frequency range: mode 0 1 Hz steps, mode 1 10 Hz.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "rpsm_defs.svh"

module rpsm_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Monitor word port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Channel configuration
	input wire logic op_mode,
	input wire logic [1:0] rev_mode,
	input wire logic word_order,
	input wire logic [4:0] start_step,
	input wire logic [15:0] int_step,
	// Step table answer for step_sel
	output logic [4:0] step_sel,
	output logic step_load,
	input wire logic [15:0] tbl_freq,
	input wire logic [15:0] tbl_time,
	input wire logic [31:0] tbl_preset,
	input wire logic [15:0] tbl_option,
	input wire logic [15:0] tbl_next,
	// Control inputs
	input wire logic exec_in,
	input wire logic int_in,
	input wire logic dir_in,
	input wire logic scan_exec,
	// Ramp engine feedback
	input wire logic pulse_tick,
	input wire logic ramping,
	// Status flags and outputs
	output logic flag_busy,
	output logic flag_done,
	output logic flag_ramp,
	output logic flag_ovf,
	output logic flag_dir,
	output logic program_error_flag,
	output logic blk_out
);
	import rpsm_pkg::*;

	rpsm_regs_t s_r;
	rpsm_regs_t s_nxt;
	logic [15:0] err_c;
	logic exec_rise;
	logic int_rise;
	logic at_preset;

	// Step check, first failing field wins
	function automatic logic [15:0] rpsm_check(
		input logic mode,
		input logic [15:0] freq,
		input logic [15:0] tim,
		input logic [31:0] preset,
		input logic [15:0] opt,
		input logic [15:0] nxt,
		input logic [15:0] istep
	);
		logic [15:0] fmin;
		fmin = mode ? `RPSM_FREQ_MIN1 : `RPSM_FREQ_MIN0;
		if (preset < `RPSM_PRESET_MIN || preset > `RPSM_PRESET_MAX) begin
			return `RPSM_ERR_PRESET;
		end
		if (freq < fmin || freq > `RPSM_FREQ_MAX) begin
			return `RPSM_ERR_FREQ;
		end
		if (tim < `RPSM_TIME_MIN || tim > `RPSM_TIME_MAX) begin
			return `RPSM_ERR_TIME;
		end
		if (opt > `RPSM_OPT_MAX) begin
			return `RPSM_ERR_OPT;
		end
		if (nxt > `RPSM_STEP_MAX) begin
			return `RPSM_ERR_NEXT;
		end
		if (istep == 16'h0000 || istep > `RPSM_STEP_MAX) begin
			return `RPSM_ERR_INT;
		end
		return `RPSM_ERR_NONE;
	endfunction

	assign err_c = rpsm_check(op_mode, tbl_freq, tbl_time, tbl_preset, tbl_option, tbl_next, int_step);
	assign exec_rise = exec_in & ~s_r.exec_q;
	assign int_rise = int_in & ~s_r.int_q;
	assign at_preset = (s_r.cnt == s_r.preset);

	always_comb begin
		s_nxt = s_r;
		s_nxt.exec_q = exec_in;
		s_nxt.int_q = int_in;
		s_nxt.step_load = 1'b0;
		unique case (s_r.state)
			RPSM_IDLE: begin
				if (exec_rise) begin
					s_nxt.step_sel = start_step;
					s_nxt.state = RPSM_CHECK;
				end
			end
			RPSM_CHECK: begin
				if (!exec_in) begin
					s_nxt.state = RPSM_IDLE;
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
				end else begin
					s_nxt.err = err_c;
					if (err_c != `RPSM_ERR_NONE) begin
						s_nxt.prog_err = 1'b1;
						s_nxt.busy = 1'b0;
						s_nxt.done = 1'b1;
						s_nxt.state = RPSM_IDLE;
					end else begin
						s_nxt.next_w = tbl_next;
						s_nxt.run_w = {11'h000, s_r.step_sel};
						s_nxt.freq_w = tbl_freq;
						s_nxt.time_w = tbl_time - (tbl_time % `RPSM_TIME_UNIT);
						s_nxt.preset = tbl_preset;
						s_nxt.cnt = `RPSM_RST_COUNT;
						s_nxt.ovf = 1'b0;
						s_nxt.busy = 1'b1;
						s_nxt.done = 1'b0;
						s_nxt.step_load = 1'b1;
						s_nxt.state = RPSM_RUN;
					end
				end
			end
			RPSM_RUN: begin
				if (!exec_in) begin
					s_nxt.state = RPSM_IDLE;
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
				end else if (int_rise) begin
					s_nxt.step_sel = int_step[4:0];
					s_nxt.state = RPSM_CHECK;
				end else if (pulse_tick) begin
					if (at_preset) begin
						s_nxt.ovf = 1'b1;
					end else begin
						s_nxt.cnt = s_r.cnt + 32'h0000_0001;
					end
				end else if (at_preset && !ramping) begin
					if (s_r.next_w == 16'h0000) begin
						s_nxt.busy = 1'b0;
						s_nxt.done = 1'b1;
						s_nxt.state = RPSM_IDLE;
					end else begin
						s_nxt.step_sel = s_r.next_w[4:0];
						s_nxt.state = RPSM_CHECK;
					end
				end
			end
		endcase
		if (scan_exec) begin
			s_nxt.cnt_mon = s_r.cnt;
		end
		s_nxt.ramp = s_nxt.busy & ramping;
		s_nxt.dir = (rev_mode != 2'h0) ? dir_in : 1'b0;
		s_nxt.out = s_nxt.done & exec_in;
		// Writes from the program are ignored: all words are read-only
		s_nxt.rdata = `RPSM_RST_WORD;
		if (reg_rd) begin
			unique case (reg_addr)
				`RPSM_OFF_NEXT: s_nxt.rdata = s_r.next_w;
				`RPSM_OFF_RUN: s_nxt.rdata = s_r.run_w;
				`RPSM_OFF_FREQ: s_nxt.rdata = s_r.freq_w;
				`RPSM_OFF_TIME: s_nxt.rdata = s_r.time_w;
				`RPSM_OFF_PRESET_A: s_nxt.rdata = word_order ? s_r.preset[15:0] : s_r.preset[31:16];
				`RPSM_OFF_PRESET_B: s_nxt.rdata = word_order ? s_r.preset[31:16] : s_r.preset[15:0];
				`RPSM_OFF_COUNT_A: s_nxt.rdata = word_order ? s_r.cnt_mon[15:0] : s_r.cnt_mon[31:16];
				`RPSM_OFF_COUNT_B: s_nxt.rdata = word_order ? s_r.cnt_mon[31:16] : s_r.cnt_mon[15:0];
				`RPSM_OFF_ERR: s_nxt.rdata = s_r.err;
				default: s_nxt.rdata = `RPSM_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign step_sel = s_r.step_sel;
	assign step_load = s_r.step_load;
	assign flag_busy = s_r.busy;
	assign flag_done = s_r.done;
	assign flag_ramp = s_r.ramp;
	assign flag_ovf = s_r.ovf;
	assign flag_dir = s_r.dir;
	assign program_error_flag = s_r.prog_err;
	assign blk_out = s_r.out;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_start_edge;
		s_r.state == RPSM_IDLE && exec_in && !s_r.exec_q;
	endsequence

	sequence seq_int_edge;
		s_r.state == RPSM_RUN && exec_in && int_in && !s_r.int_q;
	endsequence

	sequence seq_bad_check;
		s_r.state == RPSM_CHECK && exec_in && err_c != `RPSM_ERR_NONE;
	endsequence

	sequence seq_check_live;
		s_r.state == RPSM_CHECK && exec_in;
	endsequence

	sequence seq_good_check;
		seq_check_live ##0 (err_c == `RPSM_ERR_NONE);
	endsequence

	// Running with no stop or interrupt pending this cycle
	sequence seq_run_live;
		s_r.state == RPSM_RUN && exec_in && !int_rise;
	endsequence

	sequence seq_step_end;
		seq_run_live ##0 (!pulse_tick && at_preset && !ramping);
	endsequence

	a_start_step_sel: assert property (seq_start_edge |=> s_r.state == RPSM_CHECK && step_sel == $past(start_step))
		else $error("start edge did not select the start step");

	a_int_restart: assert property (seq_int_edge |=> s_r.state == RPSM_CHECK && step_sel == $past(int_step[4:0]))
		else $error("interrupt edge did not restart at the target step");

	a_err_flag_set: assert property (seq_bad_check |=> program_error_flag && s_r.err == $past(err_c) && !flag_busy)
		else $error("bad step did not raise error flag and code");

	a_out_exec_low: assert property (!exec_in |=> !blk_out)
		else $error("block output high while execution input low");

	a_busy_done_excl: assert property (flag_busy |-> !flag_done)
		else $error("busy and complete flags both high");

	a_ovf_freeze: assert property (flag_ovf && s_r.state == RPSM_RUN |=> s_r.cnt == $past(s_r.cnt))
		else $error("emitted count moved after overflow");

	a_time_trunc: assert property (s_r.state == RPSM_RUN |-> s_r.time_w % `RPSM_TIME_UNIT == 16'h0000)
		else $error("change time word keeps its last digit");

	a_run_range: assert property (s_r.state == RPSM_RUN |-> s_r.run_w >= 16'h0001 && s_r.run_w <= `RPSM_STEP_MAX)
		else $error("running step word out of range");

	a_dir_follow: assert property (rev_mode != 2'h0 |=> flag_dir == $past(dir_in))
		else $error("direction flag does not follow direction input");

	a_read_err: assert property (reg_rd && reg_addr == `RPSM_OFF_ERR |=> reg_rdata == $past(s_r.err))
		else $error("error word read returned wrong data");

	a_good_load: assert property (seq_good_check |=> s_r.state == RPSM_RUN && step_load)
		else $error("good step did not load");

	a_load_next: assert property (seq_good_check |=> s_r.next_w == $past(tbl_next))
		else $error("next step word not loaded");

	a_load_run: assert property (seq_good_check |=> s_r.run_w == {11'h000, $past(step_sel)})
		else $error("running step word not loaded");

	a_load_time: assert property (seq_good_check |=> s_r.time_w <= $past(tbl_time)
		&& s_r.time_w + `RPSM_TIME_UNIT > $past(tbl_time))
		else $error("change time word not cut to whole units");

	a_load_preset: assert property (seq_good_check |=> s_r.preset == $past(tbl_preset))
		else $error("preset words not loaded");

	a_load_clear: assert property (seq_good_check |=> s_r.cnt == `RPSM_RST_COUNT && !flag_ovf)
		else $error("step load left count or overflow set");

	a_err_preset: assert property (seq_check_live ##0 (tbl_preset > `RPSM_PRESET_MAX)
		|=> s_r.err == `RPSM_ERR_PRESET)
		else $error("preset out of range gave wrong code");

	a_err_freq: assert property (seq_check_live ##0 (tbl_freq > `RPSM_FREQ_MAX)
		|=> s_r.err == `RPSM_ERR_FREQ || s_r.err == `RPSM_ERR_PRESET)
		else $error("frequency out of range gave wrong code");

	a_mode_floor: assert property (seq_check_live ##0 (op_mode && tbl_freq < `RPSM_FREQ_MIN1)
		|=> s_r.err == `RPSM_ERR_FREQ || s_r.err == `RPSM_ERR_PRESET)
		else $error("mode 1 frequency floor not enforced");

	a_err_time: assert property (seq_check_live ##0 (tbl_time < `RPSM_TIME_MIN)
		|=> s_r.err != `RPSM_ERR_NONE && s_r.err <= `RPSM_ERR_TIME)
		else $error("short change time gave wrong code");

	a_err_option: assert property (seq_check_live ##0 (tbl_option > `RPSM_OPT_MAX)
		|=> s_r.err != `RPSM_ERR_NONE && s_r.err <= `RPSM_ERR_OPT)
		else $error("bad option gave wrong code");

	a_err_next: assert property (seq_check_live ##0 (tbl_next > `RPSM_STEP_MAX)
		|=> s_r.err != `RPSM_ERR_NONE && s_r.err <= `RPSM_ERR_NEXT)
		else $error("bad next step gave wrong code");

	a_err_int: assert property (seq_check_live ##0 (int_step == 16'h0000 || int_step > `RPSM_STEP_MAX)
		|=> s_r.err != `RPSM_ERR_NONE)
		else $error("bad interrupt step not flagged");

	a_err_codes: assert property (s_r.err <= `RPSM_ERR_INT && s_r.err != 16'h0001
		&& s_r.err != 16'h0002 && s_r.err != 16'h0006)
		else $error("error code outside the defined set");

	a_err_sticky: assert property (program_error_flag |=> program_error_flag)
		else $error("program error flag cleared");

	a_exec_stop: assert property (s_r.state != RPSM_IDLE && !exec_in
		|=> s_r.state == RPSM_IDLE && !flag_busy && flag_done)
		else $error("execution input low did not stop output");

	a_end_zero: assert property (seq_step_end ##0 (s_r.next_w == 16'h0000)
		|=> s_r.state == RPSM_IDLE && flag_done)
		else $error("last step did not complete");

	a_end_chain: assert property (seq_step_end ##0 (s_r.next_w != 16'h0000)
		|=> s_r.state == RPSM_CHECK && flag_busy && step_sel == $past(s_r.next_w[4:0]))
		else $error("finished step did not chain to the next step");

	a_count_tick: assert property (seq_run_live ##0 (pulse_tick && !at_preset)
		|=> s_r.cnt == $past(s_r.cnt) + 32'h0000_0001)
		else $error("emitted pulse not counted");

	a_ovf_set: assert property (seq_run_live ##0 (pulse_tick && at_preset) |=> flag_ovf)
		else $error("pulse beyond preset did not set overflow");

	a_cnt_bound: assert property (s_r.state == RPSM_RUN |-> s_r.cnt <= s_r.preset)
		else $error("emitted count passed the preset");

	a_ramp_follow: assert property (1'b1 |=> flag_ramp == (flag_busy && $past(ramping)))
		else $error("ramp flag does not follow the engine");

	a_out_mirror: assert property (1'b1 |=> blk_out == (flag_done && $past(exec_in)))
		else $error("block output does not mirror completion");

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == `RPSM_RST_WORD)
		else $error("read data not zero outside a read");

	a_read_cnt_hi: assert property (reg_rd && reg_addr == `RPSM_OFF_COUNT_A && !word_order
		|=> reg_rdata == $past(s_r.cnt_mon[31:16]))
		else $error("upper count word read returned wrong data");

	a_write_ignored: assert property (reg_wr && s_r.state == RPSM_IDLE
		|=> $stable(s_r.err) && $stable(s_r.next_w))
		else $error("write changed a monitor word");

endmodule
